// >>> src/cmpi_defs.svh
// register offsets, field positions, reset values and counts for the comparator irq logic
`ifndef CMPI_DEFS_SVH
`define CMPI_DEFS_SVH

`define CMPI_CH_COUNT 4
`define CMPI_ADDR_W 12
`define CMPI_ADDR_STATUS 12'h000
`define CMPI_ADDR_CONTROL 12'h004
`define CMPI_ADDR_IRQ_STATUS 12'h008
`define CMPI_ADDR_IRQ_MASK 12'h00c
`define CMPI_CTRL_RESET 8'h00
`define CMPI_STAT_RESET 8'h00
`define CMPI_ENABLE_BIT 0
`define CMPI_IRQ_EN_LSB 1
`define CMPI_EDGE_CH0_BIT 5
`define CMPI_EDGE_CH1_BIT 6
`define CMPI_EDGE_CH23_BIT 7
`define CMPI_FLAG_LSB 4
`define CMPI_HP_REQ_BIT 2
`define CMPI_HP_REQ_W 8

`endif

// >>> src/cmpi_pkg.sv
// types shared by the comparator irq logic
`include "cmpi_defs.svh"

package cmpi_pkg;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`CMPI_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} cmpi_apb_req_type;

	// complete state of the block
	typedef struct packed {
		logic [`CMPI_CH_COUNT-1:0] sync1;
		logic [`CMPI_CH_COUNT-1:0] sync2;
		logic [`CMPI_CH_COUNT-1:0] sync3;
		logic [`CMPI_CH_COUNT-1:0] live;
		logic [7:0] ctrl;
		logic [`CMPI_CH_COUNT-1:0] flag;
		logic [`CMPI_CH_COUNT-1:0] istat;
		logic [`CMPI_CH_COUNT-1:0] imask;
		logic pulse;
		logic [31:0] rdata;
	} cmpi_state_type;

endpackage : cmpi_pkg

// >>> src/cmpi_top.sv
// comparator edge detection, status flags, apb registers and interrupt output
`timescale 1ns/1ns
`default_nettype none
`include "cmpi_defs.svh"

// Contract
// R1: four independent comparator channels, 0 to 3
// R2: control bit 0 enables; off means inactive
// R3: one interrupt output combining all channels
// R4: control bits 4..1 enable channel 3..0 interrupts
// R5: bits 5,6 pick channel 0,1 edge, 1=rising
// R6: bit 7 picks common edge for channels 2,3
// R7: status bits 7..4 flag events, cleared by read
// R8: status bits 3..0 show live comparator results
// R9: all status and control bits reset to zero
// R10: software sets edges, enable, then channel enables
// R11: combined interrupt drives high-priority request bit 2
// R12: synchronise inputs, detect edges on successive samples
// R13: selected enabled edge sets flag, pulses interrupt
module cmpi_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// apb slave
	input wire cmpi_pkg::cmpi_apb_req_type apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog comparators
	input wire logic [`CMPI_CH_COUNT-1:0] comparator_result,
	output logic comparator_enable,
	// interrupt manager
	output logic cmp_irq_pulse,
	output logic [`CMPI_HP_REQ_W-1:0] high_priority_request_reg,
	output logic irq
);

	cmpi_pkg::cmpi_state_type s_q;
	cmpi_pkg::cmpi_state_type s_d;
	logic setup;
	logic access;
	logic mapped;
	logic enabled;
	logic [`CMPI_CH_COUNT-1:0] live_n;
	logic [`CMPI_CH_COUNT-1:0] rise;
	logic [`CMPI_CH_COUNT-1:0] fall;
	logic [`CMPI_CH_COUNT-1:0] rise_sel;
	logic [`CMPI_CH_COUNT-1:0] irq_en;
	logic [`CMPI_CH_COUNT-1:0] evt;
	logic [`CMPI_CH_COUNT-1:0] rd_clr;
	logic [`CMPI_CH_COUNT-1:0] w1c;
	logic [7:0] status_byte;

	// per-channel edge polarity, 1 means rising
	function automatic logic [`CMPI_CH_COUNT-1:0] edge_rising(input logic [7:0] ctrl);
		edge_rising = {ctrl[`CMPI_EDGE_CH23_BIT], ctrl[`CMPI_EDGE_CH23_BIT],
			ctrl[`CMPI_EDGE_CH1_BIT], ctrl[`CMPI_EDGE_CH0_BIT]}; // [R5] [R6]
	endfunction : edge_rising

	// true for any of the four register offsets
	function automatic logic addr_mapped(input logic [`CMPI_ADDR_W-1:0] a);
		addr_mapped = (a == `CMPI_ADDR_STATUS) || (a == `CMPI_ADDR_CONTROL) ||
			(a == `CMPI_ADDR_IRQ_STATUS) || (a == `CMPI_ADDR_IRQ_MASK);
	endfunction : addr_mapped

	// apb phase decode
	assign setup = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	assign mapped = addr_mapped(apb_req.paddr);

	// control fields
	assign enabled = s_q.ctrl[`CMPI_ENABLE_BIT];
	assign irq_en = s_q.ctrl[`CMPI_IRQ_EN_LSB +: `CMPI_CH_COUNT];
	assign rise_sel = edge_rising(s_q.ctrl);

	// debounced level: a bit changes once second and third stages agree
	assign live_n = enabled ? ((~(s_q.sync2 ^ s_q.sync3) & s_q.sync3) |
		((s_q.sync2 ^ s_q.sync3) & s_q.live)) : '0; // [R12] [R2]

	// edges from current versus previous debounced sample
	assign rise = live_n & ~s_q.live; // [R12]
	assign fall = ~live_n & s_q.live; // [R12]

	// selected edge of an enabled channel while the block is on
	assign evt = ((rise_sel & rise) | (~rise_sel & fall)) & irq_en &
		{`CMPI_CH_COUNT{enabled}}; // [R4] [R1]

	// a read clears only the flags that the read actually returned
	assign rd_clr = (access && !apb_req.pwrite && apb_req.paddr == `CMPI_ADDR_STATUS) ?
		s_q.rdata[`CMPI_FLAG_LSB +: `CMPI_CH_COUNT] : '0; // [R7]

	// write-one-to-clear on the irq status register
	assign w1c = (access && apb_req.pwrite && apb_req.paddr == `CMPI_ADDR_IRQ_STATUS) ?
		apb_req.pwdata[`CMPI_CH_COUNT-1:0] : '0;

	// event flags over live results
	assign status_byte = {s_q.flag, s_q.live}; // [R8] [R7]

	// next-state logic
	always_comb
	begin
		s_d = s_q;
		// three-stage synchroniser; held empty while off so nothing toggles
		s_d.sync1 = enabled ? comparator_result : '0; // [R12] [R2]
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
		s_d.live = live_n;
		// set wins over the read clear
		s_d.flag = (s_q.flag & ~rd_clr) | evt; // [R7] [R13]
		s_d.istat = (s_q.istat & ~w1c) | evt;
		s_d.pulse = |evt; // [R13] [R3]
		// register writes take effect at the access edge
		if (access && apb_req.pwrite)
		begin
			if (apb_req.paddr == `CMPI_ADDR_CONTROL)
			begin
				s_d.ctrl = apb_req.pwdata[7:0];
			end
			if (apb_req.paddr == `CMPI_ADDR_IRQ_MASK)
			begin
				s_d.imask = apb_req.pwdata[`CMPI_CH_COUNT-1:0];
			end
		end
		// read data is captured in the setup cycle
		if (setup && !apb_req.pwrite)
		begin
			s_d.rdata = '0;
			unique case (apb_req.paddr)
				`CMPI_ADDR_STATUS: s_d.rdata[7:0] = status_byte; // [R8]
				`CMPI_ADDR_CONTROL: s_d.rdata[7:0] = s_q.ctrl;
				`CMPI_ADDR_IRQ_STATUS: s_d.rdata[`CMPI_CH_COUNT-1:0] = s_q.istat;
				`CMPI_ADDR_IRQ_MASK: s_d.rdata[`CMPI_CH_COUNT-1:0] = s_q.imask;
				default: s_d.rdata = '0;
			endcase
		end
	end

	// state register, synchronous reset to all zero
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_q <= '0; // [R9]
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// bus answers: zero wait states, error on unmapped offsets
	assign pready = access;
	assign pslverr = access && !mapped;
	assign prdata = s_q.rdata;

	// outputs toward the analog side and the interrupt manager
	assign comparator_enable = enabled; // [R2]
	assign cmp_irq_pulse = s_q.pulse; // [R3]
	always_comb
	begin
		high_priority_request_reg = '0;
		high_priority_request_reg[`CMPI_HP_REQ_BIT] = s_q.pulse; // [R11]
	end
	assign irq = |(s_q.istat & s_q.imask);

	// assertions on flags, pulse, bus answers and reset
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_ch0_rise_armed;
		enabled && irq_en[0] && rise_sel[0] && rise[0];
	endsequence

	sequence s_status_read;
		setup && !apb_req.pwrite && apb_req.paddr == `CMPI_ADDR_STATUS
			##1 access && apb_req.paddr == `CMPI_ADDR_STATUS;
	endsequence

	property p_flag_on_edge;
		s_ch0_rise_armed |=> s_q.flag[0] && s_q.pulse;
	endproperty
	a_flag_on_edge: assert property (p_flag_on_edge) // [R13]
		else $error("enabled rising edge did not set flag and pulse");

	property p_masked_channel;
		(!irq_en[1] && !irq_en[0] && !irq_en[2] && !irq_en[3]) |=> !s_q.pulse;
	endproperty
	a_masked_channel: assert property (p_masked_channel) // [R4]
		else $error("pulse with all channel enables clear");

	property p_falling_select;
		enabled && irq_en[2] && !s_q.ctrl[`CMPI_EDGE_CH23_BIT] && rise[2] && !(|(evt & 4'hb))
			|=> !s_q.pulse;
	endproperty
	a_falling_select: assert property (p_falling_select) // [R6]
		else $error("rising edge fired on channel 2 set for falling");

	property p_edge_ch1;
		enabled && irq_en[1] && !s_q.ctrl[`CMPI_EDGE_CH1_BIT] && fall[1] |=> s_q.flag[1];
	endproperty
	a_edge_ch1: assert property (p_edge_ch1) // [R5]
		else $error("falling edge on channel 1 not flagged");

	property p_disabled_quiet;
		!enabled |-> !comparator_enable
			##1 (s_q.sync1 == '0 && s_q.live == '0 && !s_q.pulse);
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) // [R2]
		else $error("block active while disabled");

	property p_read_clears;
		s_status_read ##0 (evt == '0) |=> (s_q.flag & $past(s_q.rdata[7:4])) == '0;
	endproperty
	a_read_clears: assert property (p_read_clears) // [R7]
		else $error("status read did not clear returned flags");

	property p_live_readout;
		setup && !apb_req.pwrite && apb_req.paddr == `CMPI_ADDR_STATUS
			|=> prdata[3:0] == $past(s_q.live) && prdata[31:8] == '0;
	endproperty
	a_live_readout: assert property (p_live_readout) // [R8]
		else $error("status read returned wrong live result");

	property p_sync_follow;
		enabled && comparator_result[3] ##1 (enabled && comparator_result[3]) [*3]
			|=> s_q.live[3];
	endproperty
	a_sync_follow: assert property (p_sync_follow) // [R12]
		else $error("stable input not seen after synchroniser");

	property p_reset_zero;
		$rose(rst_n) |-> s_q.ctrl == `CMPI_CTRL_RESET && status_byte == `CMPI_STAT_RESET;
	endproperty
	a_reset_zero: assert property (p_reset_zero) // [R9]
		else $error("registers not zero after reset");

	property p_hp_bit;
		|evt |=> high_priority_request_reg[`CMPI_HP_REQ_BIT] && cmp_irq_pulse
			##1 (|$past(evt) || !cmp_irq_pulse);
	endproperty
	a_hp_bit: assert property (p_hp_bit) // [R11] [R3]
		else $error("request bit 2 does not follow the pulse");

	// level interrupt follows unmasked sticky bits
	property p_irq_unmasked;
		(s_q.istat & s_q.imask) != '0 |-> irq;
	endproperty
	a_irq_unmasked: assert property (p_irq_unmasked) // [R3]
		else $error("unmasked status bit without interrupt");

	property p_irq_quiet;
		(s_q.istat & s_q.imask) == '0 |-> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) // [R3]
		else $error("interrupt high with nothing unmasked");

	// flags stay until a read returns them
	property p_flag_sticky;
		s_q.flag != '0 |=> ($past(s_q.flag) & ~$past(rd_clr) & ~s_q.flag) == '0;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) // [R7]
		else $error("event flag lost without a status read");

	property p_off_no_new_flag;
		!enabled |=> (s_q.flag & ~$past(s_q.flag)) == '0;
	endproperty
	a_off_no_new_flag: assert property (p_off_no_new_flag) // [R2]
		else $error("flag set while block disabled");

	property p_needs_irq_enable;
		1'b1 |=> (s_q.flag & ~$past(s_q.flag) & ~$past(irq_en)) == '0;
	endproperty
	a_needs_irq_enable: assert property (p_needs_irq_enable) // [R4]
		else $error("flag set on a channel with its enable clear");

	// edge selection per channel
	property p_ch3_falling;
		enabled && irq_en[3] && !s_q.ctrl[`CMPI_EDGE_CH23_BIT] && fall[3]
			|=> s_q.flag[3] && s_q.pulse;
	endproperty
	a_ch3_falling: assert property (p_ch3_falling) // [R6]
		else $error("falling edge on channel 3 not flagged");

	property p_ch0_falling;
		enabled && irq_en[0] && !s_q.ctrl[`CMPI_EDGE_CH0_BIT] && fall[0] |=> s_q.flag[0];
	endproperty
	a_ch0_falling: assert property (p_ch0_falling) // [R5]
		else $error("falling edge on channel 0 not flagged");

	property p_ch1_rising;
		enabled && irq_en[1] && s_q.ctrl[`CMPI_EDGE_CH1_BIT] && rise[1]
			|=> s_q.flag[1] && s_q.pulse;
	endproperty
	a_ch1_rising: assert property (p_ch1_rising) // [R5]
		else $error("rising edge on channel 1 not flagged");

	property p_pulse_needs_event;
		evt == '0 |=> !s_q.pulse;
	endproperty
	a_pulse_needs_event: assert property (p_pulse_needs_event) // [R13]
		else $error("interrupt pulse without an event");

	property p_event_latched;
		evt != '0 |=> (s_q.flag & $past(evt)) == $past(evt)
			&& (s_q.istat & $past(evt)) == $past(evt);
	endproperty
	a_event_latched: assert property (p_event_latched) // [R7] [R13]
		else $error("event not latched in flag and status");

	// live bit moves only where stages two and three agree
	property p_glitch_held;
		enabled |=> ((s_q.live ^ $past(s_q.live))
			& ($past(s_q.sync2) ^ $past(s_q.sync3))) == '0;
	endproperty
	a_glitch_held: assert property (p_glitch_held) // [R12]
		else $error("live bit changed while synchroniser stages differ");

	property p_live_on_agree;
		enabled |=> ((s_q.live ^ $past(s_q.sync3))
			& ~($past(s_q.sync2) ^ $past(s_q.sync3))) == '0;
	endproperty
	a_live_on_agree: assert property (p_live_on_agree) // [R12]
		else $error("live bit did not take agreed synchroniser value");

	// control register writes and holds
	sequence s_ctrl_write;
		access && apb_req.pwrite && apb_req.paddr == `CMPI_ADDR_CONTROL;
	endsequence

	property p_ctrl_write;
		s_ctrl_write |=> s_q.ctrl == $past(apb_req.pwdata[7:0])
			&& comparator_enable == $past(apb_req.pwdata[`CMPI_ENABLE_BIT]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) // [R2] [R4]
		else $error("control write did not land");

	property p_ctrl_hold;
		!(access && apb_req.pwrite && apb_req.paddr == `CMPI_ADDR_CONTROL)
			|=> $stable(s_q.ctrl);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) // [R4]
		else $error("control changed without a write");

	property p_hp_others_zero;
		1'b1 |-> high_priority_request_reg[`CMPI_HP_REQ_BIT-1:0] == '0
			&& high_priority_request_reg[`CMPI_HP_REQ_W-1:`CMPI_HP_REQ_BIT+1] == '0;
	endproperty
	a_hp_others_zero: assert property (p_hp_others_zero) // [R11]
		else $error("request bits other than bit 2 are set");

	property p_flags_readout;
		setup && !apb_req.pwrite && apb_req.paddr == `CMPI_ADDR_STATUS
			|=> prdata[7:4] == $past(s_q.flag);
	endproperty
	a_flags_readout: assert property (p_flags_readout) // [R7]
		else $error("status read returned wrong event flags");

	property p_irq_clear;
		access && apb_req.pwrite && apb_req.paddr == `CMPI_ADDR_IRQ_STATUS && evt == '0
			|=> (s_q.istat & $past(apb_req.pwdata[`CMPI_CH_COUNT-1:0])) == '0;
	endproperty
	a_irq_clear: assert property (p_irq_clear) // [R3]
		else $error("write of ones did not clear status bits");

endmodule : cmpi_top
`default_nettype wire

// >>> verification/cmpi_comp_model.sv
// behavioural model of the four analog comparators
`timescale 1ns/1ns
`default_nettype none
module cmpi_comp_model (
	// clock
	input wire logic sys_clk,
	// power control from the block, wanted levels from the bench
	input wire logic comparator_enable,
	input wire logic [3:0] level,
	// comparison results
	output logic [3:0] comparator_result
);
	// powered down outputs toggle every cycle, so nothing may trust them
	initial comparator_result = 4'h0;
	always @(posedge sys_clk)
	begin
		if (comparator_enable)
			comparator_result <= level;
		else
			comparator_result <= ~comparator_result;
	end
endmodule : cmpi_comp_model
`default_nettype wire

// >>> verification/test_comparator_irq_logic.sv
// self-checking bench for the comparator irq logic
`timescale 1ns/1ns
`default_nettype none
`include "cmpi_defs.svh"
module test_comparator_irq_logic;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] lvl = 4'h0;
	logic [3:0] res;
	logic [31:0] prdata;
	logic pready, pslverr, en, pulse, irq;
	logic [7:0] hp;
	cmpi_pkg::cmpi_apb_req_type rq = '0;
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	// 250 MHz clock
	always #2 sys_clk = ~sys_clk;
	// block under test and its comparators
	cmpi_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(rq), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .comparator_result(res),
		.comparator_enable(en), .cmp_irq_pulse(pulse),
		.high_priority_request_reg(hp), .irq(irq));
	cmpi_comp_model cmp_u (.sys_clk(sys_clk), .comparator_enable(en), .level(lvl),
		.comparator_result(res));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		rq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk);
		rq.penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
		begin
			@(posedge sys_clk);
		end
		rd = prdata;
		er = pslverr;
		rq.psel <= 1'b0;
		rq.penable <= 1'b0;
	endtask : apb
	// set comparator levels and let the synchroniser settle
	task automatic settle(input logic [3:0] v);
		lvl <= v;
		repeat (8) @(posedge sys_clk);
	endtask : settle
	// status and control read zero after reset; en, irq and pulse low
	task automatic t_reset;
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `CMPI_ADDR_CONTROL, 32'h0);
		chk(rd, 32'h0);
		chk(32'({en, irq, pulse}), 32'h0);
		$display("reset test done");
	endtask : t_reset
	// edges, flags, pulse and level interrupt
	task automatic t_edges;
		int n;
		n = 0;
		apb(1'b1, `CMPI_ADDR_CONTROL, 32'ha1);
		@(posedge sys_clk);
		chk(32'(en), 32'h1);
		apb(1'b1, `CMPI_ADDR_CONTROL, 32'haf);
		settle(4'b0010);
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'h02);
		lvl <= 4'b0001;
		@(posedge sys_clk);
		while (pulse !== 1'b1 && n < 10)
		begin
			n++;
			@(posedge sys_clk);
		end
		chk(32'(hp), 32'h04);
		@(posedge sys_clk);
		chk(32'(pulse), 32'h0);
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'h31);
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'h01);
		settle(4'b1101);
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'h4d);
		apb(1'b0, `CMPI_ADDR_IRQ_STATUS, 32'h0);
		chk(rd, 32'h07);
		chk(32'(irq), 32'h0);
		apb(1'b1, `CMPI_ADDR_IRQ_MASK, 32'h01);
		@(negedge sys_clk);
		chk(32'(irq), 32'h1);
		apb(1'b1, `CMPI_ADDR_IRQ_STATUS, 32'h07);
		@(negedge sys_clk);
		chk(32'(irq), 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h0);
		chk(32'(er), 32'h1);
		$display("edge test done");
	endtask : t_edges
	// disabled block shows no live results
	task automatic t_off;
		apb(1'b1, `CMPI_ADDR_CONTROL, 32'h0);
		settle(4'b1111);
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		chk(32'(en), 32'h0);
		$display("disable test done");
	endtask : t_off
	// falling edges on channels 0, 2, 3, rising on channel 1, then a mid-run reset
	task automatic t_falling;
		apb(1'b1, `CMPI_ADDR_CONTROL, 32'h41);
		settle(4'b1111);
		apb(1'b1, `CMPI_ADDR_CONTROL, 32'h5f);
		settle(4'b0000);
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'hd0);
		settle(4'b0100);
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'h04);
		settle(4'b0110);
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'h26);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		apb(1'b0, `CMPI_ADDR_CONTROL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `CMPI_ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		chk(32'(en), 32'h0);
		$display("falling edge and reset test done");
	endtask : t_falling
	// counts and verdict
	task automatic print_verdict;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// main sequence
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset;
		t_edges;
		t_off;
		t_falling;
		print_verdict;
	end
	// hang guard
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count++;
			print_verdict;
		end
	end
endmodule : test_comparator_irq_logic
`default_nettype wire
